// [hdl/isf_pkg.sv]
/*
  Constants and carrier types for the bus event flag block of an I2C interface.
  Assumes a single 10 MHz system clock and a 32-bit Avalon-MM register port.
*/
package isf_pkg;

  localparam int CLK_PERIOD_NS = 100;
  localparam int LINK_PERIOD_NS = 800;
  localparam int LINK_SAMPLES = LINK_PERIOD_NS / CLK_PERIOD_NS;

  localparam logic [3:0] OFS_FLAGS = 4'h0;
  localparam logic [3:0] OFS_EVT_STATUS = 4'h4;
  localparam logic [3:0] OFS_EVT_MASK = 4'h8;

  localparam int BIT_ERR_HALT = 7;
  localparam int BIT_NORM_STOP = 6;
  localparam int BIT_XFER_REQ = 5;
  localparam int BIT_SECOND_MATCH = 4;
  localparam int BIT_ARB_LOST = 3;
  localparam int BIT_OWN_MATCH = 2;
  localparam int BIT_GENERAL_CALL = 1;
  localparam int BIT_ACK = 0;

  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] EVT_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] GENERAL_CALL_ADDR = 8'h00;
  localparam logic [7:0] FLAG_BITS = 8'hFE;

  typedef struct packed {
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic sda_level;
  } isf_line_t;

  typedef struct packed {
    logic master_mode;
    logic transmit_select;
    logic frame_busy;
    logic primary_format_select;
    logic second_format_select;
  } isf_mode_t;

endpackage : isf_pkg

// [hdl/isf_line_watch.sv]
/*
  Samples the SCL and SDA pins on the system clock and reports the SCL edges
  and the start and stop conditions as one-cycle pulses.
  Assumes the link clock is at least a few system clocks long per phase.
*/
`timescale 1ns/10ps
module isf_line_watch (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic scl_pin,
  input wire logic sda_pin,
  output isf_pkg::isf_line_t line
);

  logic [1:0] scl_sync_r;
  logic [1:0] sda_sync_r;
  logic scl_last_r;
  logic sda_last_r;
  isf_pkg::isf_line_t line_r;

  // Only the second stage of each synchroniser feeds the edge logic.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
    end else begin
      scl_sync_r <= {scl_sync_r[0], scl_pin};
      sda_sync_r <= {sda_sync_r[0], sda_pin};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_last_r <= 1'h1;
      sda_last_r <= 1'h1;
    end else begin
      scl_last_r <= scl_sync_r[1];
      sda_last_r <= sda_sync_r[1];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      line_r <= '0;
    end else begin
      line_r.scl_rise <= scl_sync_r[1] & ~scl_last_r;
      line_r.scl_fall <= ~scl_sync_r[1] & scl_last_r;
      line_r.start_seen <= scl_sync_r[1] & scl_last_r & ~sda_sync_r[1] & sda_last_r;
      line_r.stop_seen <= scl_sync_r[1] & scl_last_r & sda_sync_r[1] & ~sda_last_r;
      line_r.sda_level <= sda_sync_r[1];
    end
  end

  assign line = line_r;

endmodule : isf_line_watch

// [hdl/isf_flags.sv]
/*
  Status and acknowledge flag logic of an I2C bus interface, with its own
  Avalon-MM register port and one level interrupt.
  Assumes the transfer engine supplies mode levels, address frames, transfer
  done pulses and data register access pulses on the same clock.
*/
`timescale 1ns/10ps
module isf_flags (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic hw_standby,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  input wire logic scl_pin,
  input wire logic sda_pin,
  input wire logic internal_sda,
  input wire logic internal_scl,
  input isf_pkg::isf_mode_t mode,
  input wire logic [6:0] own_addr,
  input wire logic [6:0] second_addr,
  input wire logic addr_frame_valid,
  input wire logic [7:0] addr_frame,
  input wire logic transmit_empty_set,
  input wire logic receive_full_set,
  input wire logic ack_capture,
  input wire logic data_reg_write,
  input wire logic data_reg_read,
  input wire logic main_interrupt_clear,
  output logic main_interrupt_set,
  output logic ack_drive
);

  isf_pkg::isf_line_t line;
  logic [7:0] flags_r;
  logic [7:0] flags_nxt;
  logic [7:0] seen_r;
  logic [7:0] seen_nxt;
  logic [7:0] evt_r;
  logic [7:0] mask_r;
  logic ack_rx_r;
  logic ack_sw_r;
  logic bus_ack_r;
  logic [31:0] readdata_r;
  logic main_set_r;
  logic [7:0] set_vec;
  logic [7:0] clr_vec;
  logic [7:0] sw_clr;
  logic [7:0] status_view;
  logic slave_rx;
  logic data_clr;
  logic wr_take;
  logic rd_take;

  function automatic logic addr_match(input logic [7:0] frame, input logic [6:0] addr);
    addr_match = (frame[7:1] == addr);
  endfunction : addr_match

  function automatic logic reg_hit(input logic [3:0] adr, input logic [3:0] ofs);
    reg_hit = (adr == ofs);
  endfunction : reg_hit

  isf_line_watch u_line_watch (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .scl_pin(scl_pin),
    .sda_pin(sda_pin),
    .line(line)
  );

  // One wait state per access: the first cycle prepares read data, the
  // second one completes the transfer with waitrequest low.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_ack_r <= 1'h0;
    end else begin
      bus_ack_r <= (avs_read | avs_write) & ~bus_ack_r;
    end
  end

  assign avs_waitrequest = (avs_read | avs_write) & ~bus_ack_r;
  assign wr_take = avs_write & bus_ack_r;
  assign rd_take = avs_read & bus_ack_r;

  always_comb begin
    status_view = flags_r;
    status_view[isf_pkg::BIT_ACK] = mode.transmit_select ? ack_rx_r : ack_sw_r;
  end

  // Unmapped addresses read as zero and ignore writes.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      readdata_r <= 32'h0000_0000;
    end else if (avs_read & ~bus_ack_r) begin
      if (reg_hit(avs_address, isf_pkg::OFS_FLAGS)) begin
        readdata_r <= {24'h00_0000, status_view};
      end else if (reg_hit(avs_address, isf_pkg::OFS_EVT_STATUS)) begin
        readdata_r <= {24'h00_0000, evt_r};
      end else if (reg_hit(avs_address, isf_pkg::OFS_EVT_MASK)) begin
        readdata_r <= {24'h00_0000, mask_r};
      end else begin
        readdata_r <= 32'h0000_0000;
      end
    end
  end

  assign avs_readdata = readdata_r;

  assign slave_rx = ~mode.master_mode & ~mode.transmit_select;
  assign data_clr = (data_reg_write & mode.transmit_select) | (data_reg_read & ~mode.transmit_select);

  always_comb begin
    set_vec = 8'h00;
    set_vec[isf_pkg::BIT_ERR_HALT] = line.stop_seen & ~mode.master_mode & mode.frame_busy;
    set_vec[isf_pkg::BIT_NORM_STOP] = line.stop_seen & ~mode.master_mode & ~mode.frame_busy;
    set_vec[isf_pkg::BIT_XFER_REQ] = (transmit_empty_set | receive_full_set)
      & (mode.master_mode | flags_r[isf_pkg::BIT_SECOND_MATCH]);
    set_vec[isf_pkg::BIT_SECOND_MATCH] = addr_frame_valid & slave_rx & ~mode.second_format_select
      & addr_match(addr_frame, second_addr);
    set_vec[isf_pkg::BIT_ARB_LOST] = mode.master_mode & mode.transmit_select
      & ((line.scl_rise & (internal_sda != line.sda_level))
      | (line.scl_fall & internal_scl));
    set_vec[isf_pkg::BIT_OWN_MATCH] = addr_frame_valid & slave_rx & ~mode.primary_format_select
      & (addr_match(addr_frame, own_addr) | (addr_frame == isf_pkg::GENERAL_CALL_ADDR));
    set_vec[isf_pkg::BIT_GENERAL_CALL] = addr_frame_valid & slave_rx
      & (~mode.primary_format_select | ~mode.second_format_select)
      & (addr_frame == isf_pkg::GENERAL_CALL_ADDR);
  end

  // A zero write only clears a flag that software has already seen as one.
  always_comb begin
    sw_clr = 8'h00;
    if (wr_take & reg_hit(avs_address, isf_pkg::OFS_FLAGS)) begin
      sw_clr = ~avs_writedata[7:0] & seen_r & isf_pkg::FLAG_BITS;
    end
  end

  always_comb begin
    clr_vec = sw_clr;
    clr_vec[isf_pkg::BIT_ERR_HALT] = sw_clr[isf_pkg::BIT_ERR_HALT] | main_interrupt_clear;
    clr_vec[isf_pkg::BIT_NORM_STOP] = sw_clr[isf_pkg::BIT_NORM_STOP] | main_interrupt_clear;
    clr_vec[isf_pkg::BIT_XFER_REQ] = sw_clr[isf_pkg::BIT_XFER_REQ] | main_interrupt_clear;
    clr_vec[isf_pkg::BIT_SECOND_MATCH] = sw_clr[isf_pkg::BIT_SECOND_MATCH] | line.start_seen
      | mode.master_mode;
    clr_vec[isf_pkg::BIT_ARB_LOST] = sw_clr[isf_pkg::BIT_ARB_LOST] | data_clr;
    clr_vec[isf_pkg::BIT_OWN_MATCH] = sw_clr[isf_pkg::BIT_OWN_MATCH] | data_clr | mode.master_mode;
    clr_vec[isf_pkg::BIT_GENERAL_CALL] = sw_clr[isf_pkg::BIT_GENERAL_CALL] | data_clr
      | mode.master_mode;
  end

  // A set in the same cycle as any clr_vec clear wins, so only hw_standby drops an event.
  assign flags_nxt = (set_vec | (flags_r & ~clr_vec)) & isf_pkg::FLAG_BITS;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_r <= isf_pkg::FLAGS_RESET;
    end else if (hw_standby) begin
      flags_r <= isf_pkg::FLAGS_RESET;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // The seen mark is dropped by every new set, so a late event needs another read.
  always_comb begin
    seen_nxt = seen_r;
    if (rd_take & reg_hit(avs_address, isf_pkg::OFS_FLAGS)) begin
      seen_nxt = seen_r | (readdata_r[7:0] & flags_r);
    end
    seen_nxt = seen_nxt & ~set_vec & flags_nxt & isf_pkg::FLAG_BITS;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      seen_r <= 8'h00;
    end else if (hw_standby) begin
      seen_r <= 8'h00;
    end else begin
      seen_r <= seen_nxt;
    end
  end

  // The request flag and the main interrupt rise at the same edge.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      main_set_r <= 1'h0;
    end else begin
      main_set_r <= set_vec[isf_pkg::BIT_XFER_REQ] & ~hw_standby;
    end
  end

  assign main_interrupt_set = main_set_r;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_rx_r <= 1'h0;
    end else if (hw_standby) begin
      ack_rx_r <= 1'h0;
    end else if (ack_capture & mode.transmit_select) begin
      ack_rx_r <= line.sda_level;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_sw_r <= 1'h0;
    end else if (hw_standby) begin
      ack_sw_r <= 1'h0;
    end else if (wr_take & reg_hit(avs_address, isf_pkg::OFS_FLAGS)) begin
      ack_sw_r <= avs_writedata[isf_pkg::BIT_ACK];
    end
  end

  assign ack_drive = ack_sw_r;

  // Interrupt events: sticky, write one to clear, set beats clear.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_r <= isf_pkg::EVT_RESET;
    end else if (hw_standby) begin
      evt_r <= isf_pkg::EVT_RESET;
    end else if (wr_take & reg_hit(avs_address, isf_pkg::OFS_EVT_STATUS)) begin
      evt_r <= set_vec | (evt_r & ~avs_writedata[7:0]);
    end else begin
      evt_r <= evt_r | set_vec;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_r <= isf_pkg::MASK_RESET;
    end else if (wr_take & reg_hit(avs_address, isf_pkg::OFS_EVT_MASK)) begin
      mask_r <= avs_writedata[7:0] & isf_pkg::FLAG_BITS;
    end
  end

  assign irq = |(evt_r & mask_r);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_standby_zero: assert property (hw_standby |=> flags_r == isf_pkg::FLAGS_RESET)
    else $error("Flags not zero after standby.");

  a_error_halt_set: assert property ($rose(flags_r[isf_pkg::BIT_ERR_HALT])
    |-> $past(line.stop_seen) && $past(mode.frame_busy) && !$past(mode.master_mode))
    else $error("Error halt flag rose without a mid-frame stop.");

  a_no_stored_one: assert property (wr_take && reg_hit(avs_address, isf_pkg::OFS_FLAGS)
    |=> (flags_r & ~$past(flags_r) & ~$past(set_vec)) == 8'h00)
    else $error("Written one stored in a flag bit.");

  a_stop_main_clear: assert property (main_interrupt_clear && !set_vec[isf_pkg::BIT_ERR_HALT]
    && !set_vec[isf_pkg::BIT_NORM_STOP]
    |=> !flags_r[isf_pkg::BIT_ERR_HALT] && !flags_r[isf_pkg::BIT_NORM_STOP])
    else $error("Stop flags survived main interrupt clear.");

  a_stop_flag_set: assert property (line.stop_seen && !mode.master_mode && !mode.frame_busy && !hw_standby
    |=> flags_r[isf_pkg::BIT_NORM_STOP])
    else $error("Normal stop flag not set.");

  a_request_set: assert property ((transmit_empty_set || receive_full_set) && !hw_standby
    && (mode.master_mode || flags_r[isf_pkg::BIT_SECOND_MATCH]) |=> flags_r[isf_pkg::BIT_XFER_REQ])
    else $error("Request flag not set on empty or full.");

  a_request_with_main: assert property ($rose(flags_r[isf_pkg::BIT_XFER_REQ]) |-> main_interrupt_set)
    else $error("Request flag rose without main interrupt set.");

  a_request_main_clear: assert property (main_interrupt_clear && !set_vec[isf_pkg::BIT_XFER_REQ]
    |=> !flags_r[isf_pkg::BIT_XFER_REQ])
    else $error("Request flag survived main interrupt clear.");

  a_second_match_set: assert property (addr_frame_valid && slave_rx && !mode.second_format_select
    && addr_frame[7:1] == second_addr && !hw_standby |=> flags_r[isf_pkg::BIT_SECOND_MATCH])
    else $error("Second address match not flagged.");

  a_second_start_clear: assert property (line.start_seen && !set_vec[isf_pkg::BIT_SECOND_MATCH]
    |=> !flags_r[isf_pkg::BIT_SECOND_MATCH])
    else $error("Second match flag survived a start.");

  a_arb_sda_set: assert property (mode.master_mode && mode.transmit_select && line.scl_rise
    && internal_sda != line.sda_level && !hw_standby |=> flags_r[isf_pkg::BIT_ARB_LOST])
    else $error("SDA mismatch did not flag arbitration lost.");

  a_arb_lost_set: assert property (mode.master_mode && mode.transmit_select && line.scl_fall
    && internal_scl && !hw_standby |=> flags_r[isf_pkg::BIT_ARB_LOST])
    else $error("Arbitration lost not flagged.");

  a_arb_data_clear: assert property (data_clr && !set_vec[isf_pkg::BIT_ARB_LOST]
    |=> !flags_r[isf_pkg::BIT_ARB_LOST])
    else $error("Arbitration flag survived data access.");

  a_own_data_clear: assert property (data_clr && !set_vec[isf_pkg::BIT_OWN_MATCH]
    |=> !flags_r[isf_pkg::BIT_OWN_MATCH])
    else $error("Own match flag survived data access.");

  a_general_call_both: assert property (addr_frame_valid && slave_rx && !mode.primary_format_select
    && addr_frame == isf_pkg::GENERAL_CALL_ADDR && !hw_standby
    |=> flags_r[isf_pkg::BIT_OWN_MATCH] && flags_r[isf_pkg::BIT_GENERAL_CALL])
    else $error("General call did not set both match flags.");

  a_ack_rx_load: assert property (ack_capture && mode.transmit_select && !hw_standby
    |=> ack_rx_r == $past(line.sda_level))
    else $error("Received acknowledge not loaded.");

  a_unread_write_keeps: assert property (wr_take && reg_hit(avs_address, isf_pkg::OFS_FLAGS)
    && !avs_writedata[isf_pkg::BIT_NORM_STOP] && !seen_r[isf_pkg::BIT_NORM_STOP]
    && flags_r[isf_pkg::BIT_NORM_STOP] && !main_interrupt_clear && !hw_standby
    |=> flags_r[isf_pkg::BIT_NORM_STOP])
    else $error("Unread flag cleared by a zero write.");

  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("Bus access not answered after one wait state.");

  c_arb_lost: cover property ($rose(flags_r[isf_pkg::BIT_ARB_LOST]));
  c_read_clear: cover property (seen_r[isf_pkg::BIT_NORM_STOP] ##1 !flags_r[isf_pkg::BIT_NORM_STOP]);
  c_irq: cover property ($rose(irq));
  c_general_call: cover property ($rose(flags_r[isf_pkg::BIT_GENERAL_CALL]));

endmodule : isf_flags

// [test/isf_bus_peer.sv]
/*
  Far-side I2C party: a behavioural model that drives its own open-drain
  SCL and SDA levels with start, stop and single-bit clocking.
  Assumes the bench pulls both lines up and wires SDA together with the device.
*/
`timescale 1ns/10ps
module isf_bus_peer (
  output logic scl_o,
  output logic sda_o
);
  localparam int HALF = isf_pkg::LINK_PERIOD_NS / 2;

  // Released lines rest high by the pull-up, and the clock stands still between frames.
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  task automatic start_cond();
    scl_o = 1'b1;
    #HALF;
    sda_o = 1'b0;
    #HALF;
    scl_o = 1'b0;
    #HALF;
  endtask : start_cond

  task automatic stop_cond();
    scl_o = 1'b0;
    sda_o = 1'b0;
    #HALF;
    scl_o = 1'b1;
    #HALF;
    sda_o = 1'b1;
    #HALF;
  endtask : stop_cond

  // SDA only moves while SCL is low, so no false start or stop is made.
  task automatic clock_bit(input logic b);
    scl_o = 1'b0;
    sda_o = b;
    #HALF;
    scl_o = 1'b1;
    #HALF;
    scl_o = 1'b0;
    #HALF;
    sda_o = 1'b1;
  endtask : clock_bit
endmodule : isf_bus_peer

// [test/i2c_status_flag_logic_tb_top.sv]
/*
  Self-checking bench for the bus event flag block: a row table of flag events,
  then hand-written reset, clearing, acknowledge, arbitration and interrupt cases.
  Assumes the package and the far-side bus model are compiled before it.
*/
`timescale 1ns/10ps
module i2c_status_flag_logic_tb_top;
  typedef struct packed {
    isf_pkg::isf_mode_t md;
    logic [7:0] pv;
    logic [7:0] arg;
    logic [7:0] exp;
  } isf_row_t;
  localparam logic [7:0] P_CLR = 8'h01, P_DRD = 8'h02, P_DWR = 8'h04, P_ACK = 8'h08;
  localparam logic [7:0] P_FRM = 8'h10, P_FULL = 8'h20, P_EMPTY = 8'h40, P_STBY = 8'h80;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, irq, main_interrupt_set, ack_drive;
  logic internal_sda = 1'b1;
  logic internal_scl = 1'b0;
  isf_pkg::isf_mode_t mode = '0;
  logic [7:0] addr_frame = 8'h00;
  logic [7:0] pz = 8'h00;
  logic hw_standby, transmit_empty_set, receive_full_set, addr_frame_valid;
  logic ack_capture, data_reg_write, data_reg_read, main_interrupt_clear;
  logic peer_scl, peer_sda;
  logic [31:0] rd;
  int error_cnt = 0;
  int compares = 0;
  isf_row_t rows [13];

  // All single-cycle strobes come from one vector so one task can pulse any of them.
  assign {hw_standby, transmit_empty_set, receive_full_set, addr_frame_valid} = pz[7:4];
  assign {ack_capture, data_reg_write, data_reg_read, main_interrupt_clear} = pz[3:0];

  always #(isf_pkg::CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;

  isf_bus_peer peer (.scl_o(peer_scl), .sda_o(peer_sda));

  isf_flags dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .hw_standby(hw_standby), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
    .scl_pin(peer_scl), .sda_pin(peer_sda & internal_sda), .internal_sda(internal_sda),
    .internal_scl(internal_scl), .mode(mode), .own_addr(7'h2A), .second_addr(7'h15),
    .addr_frame_valid(addr_frame_valid), .addr_frame(addr_frame),
    .transmit_empty_set(transmit_empty_set), .receive_full_set(receive_full_set),
    .ack_capture(ack_capture), .data_reg_write(data_reg_write), .data_reg_read(data_reg_read),
    .main_interrupt_clear(main_interrupt_clear), .main_interrupt_set(main_interrupt_set),
    .ack_drive(ack_drive)
  );

  task automatic ck(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : ck

  // One Avalon transfer, held until waitrequest is seen low at a rising edge.
  task automatic xf(input logic w, input logic [3:0] a, input logic [7:0] wd);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= {24'h0, wd};
    avs_write <= w;
    avs_read <= ~w;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0 && n < 20) begin
      @(posedge ref_clk);
      n++;
    end
    ck("waitrequest", 32'h0, {31'h0, avs_waitrequest});
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask : xf

  task automatic rc(input string nm, input logic [3:0] a, input logic [7:0] e);
    xf(1'b0, a, 8'h00);
    ck(nm, {24'h0, e}, rd);
  endtask : rc

  task automatic pl(input logic [7:0] v, input logic ms);
    pz <= v;
    @(posedge ref_clk);
    pz <= 8'h00;
    #1;
    ck("main_interrupt_set", {31'h0, ms}, {31'h0, main_interrupt_set});
    repeat (3) @(posedge ref_clk);
  endtask : pl

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up

  // The whole sequence needs well under 5000 cycles; this span is generous.
  initial begin
    #2000000;
    error_cnt++;
    wrap_up();
  end

  initial begin
    rows = '{'{5'h18, P_EMPTY, 8'h00, 8'h20}, '{5'h10, P_FULL, 8'h00, 8'h20},
             '{5'h00, P_FULL, 8'h00, 8'h00}, '{5'h00, P_FRM, 8'h54, 8'h04},
             '{5'h00, P_FRM, 8'h00, 8'h06}, '{5'h00, P_FRM, 8'h2A, 8'h10},
             '{5'h01, P_FRM, 8'h2A, 8'h00}, '{5'h00, P_FRM, 8'h7E, 8'h00},
             '{5'h02, P_FRM, 8'h54, 8'h00}, '{5'h02, P_FRM, 8'h00, 8'h02},
             '{5'h03, P_FRM, 8'h00, 8'h00},
             '{5'h04, 8'h00, 8'h00, 8'h80}, '{5'h00, 8'h00, 8'h00, 8'h40}};
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rc("flags reset", 4'h0, 8'h00);
    rc("status reset", 4'h4, 8'h00);
    rc("mask reset", 4'h8, 8'h00);
    // A zero pulse vector in a row stands for a stop condition from the far side.
    foreach (rows[i]) begin
      mode <= rows[i].md;
      addr_frame <= rows[i].arg;
      @(posedge ref_clk);
      if (rows[i].pv == 8'h00) begin
        peer.stop_cond();
        repeat (6) @(posedge ref_clk);
      end else begin
        pl(rows[i].pv, rows[i].exp[5]);
      end
      rc("flags row", 4'h0, rows[i].exp);
      xf(1'b1, 4'h0, 8'h00);
      rc("flags cleared", 4'h0, 8'h00);
    end
    addr_frame <= 8'h54;
    pl(P_FRM, 1'b0);
    peer.stop_cond();
    repeat (6) @(posedge ref_clk);
    xf(1'b1, 4'h0, 8'h00);
    rc("unread zero write", 4'h0, 8'h44);
    pl(P_CLR, 1'b0);
    pl(P_DRD, 1'b0);
    rc("data read clear", 4'h0, 8'h00);
    addr_frame <= 8'h2A;
    pl(P_FRM, 1'b0);
    mode <= 5'h10;
    @(posedge ref_clk);
    rc("master clear", 4'h0, 8'h00);
    mode <= 5'h00;
    pl(P_FRM, 1'b0);
    pl(P_FULL, 1'b1);
    rc("slave request", 4'h0, 8'h30);
    peer.start_cond();
    repeat (6) @(posedge ref_clk);
    rc("start clear", 4'h0, 8'h20);
    peer.stop_cond();
    repeat (6) @(posedge ref_clk);
    rc("stop flag", 4'h0, 8'h60);
    pl(P_CLR, 1'b0);
    rc("main clear", 4'h0, 8'h00);
    xf(1'b1, 4'h0, 8'hFE);
    rc("ones ignored", 4'h0, 8'h00);
    mode <= 5'h18;
    peer.clock_bit(1'b0);
    repeat (6) @(posedge ref_clk);
    rc("sda mismatch", 4'h0, 8'h08);
    pl(P_DWR, 1'b0);
    rc("data write clear", 4'h0, 8'h00);
    internal_scl <= 1'b1;
    peer.clock_bit(1'b1);
    repeat (6) @(posedge ref_clk);
    rc("scl held high", 4'h0, 8'h08);
    internal_scl <= 1'b0;
    xf(1'b1, 4'h0, 8'h00);
    mode <= 5'h08;
    pl(P_ACK, 1'b0);
    rc("received ack", 4'h0, 8'h01);
    mode <= 5'h00;
    @(posedge ref_clk);
    rc("software ack", 4'h0, 8'h00);
    xf(1'b1, 4'h0, 8'h01);
    ck("ack_drive", 32'h1, {31'h0, ack_drive});
    addr_frame <= 8'h54;
    pl(P_FRM, 1'b0);
    pl(P_STBY, 1'b0);
    rc("standby flags", 4'h0, 8'h00);
    ck("standby ack", 32'h0, {31'h0, ack_drive});
    pl(P_FRM, 1'b0);
    ck("irq masked", 32'h0, {31'h0, irq});
    xf(1'b1, 4'h8, 8'h04);
    ck("irq raised", 32'h1, {31'h0, irq});
    rc("event status", 4'h4, 8'h04);
    xf(1'b1, 4'h4, 8'h04);
    ck("irq cleared", 32'h0, {31'h0, irq});
    rc("mask kept", 4'h8, 8'h04);
    xf(1'b1, 4'hC, 8'hFF);
    rc("unmapped", 4'hC, 8'h00);
    // A reset in mid-run must also clear the mask, which standby keeps.
    xf(1'b1, 4'h0, 8'h01);
    pl(P_FRM, 1'b0);
    ck("irq before reset", 32'h1, {31'h0, irq});
    rst_n <= 1'h0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'h1;
    @(posedge ref_clk);
    ck("irq after reset", 32'h0, {31'h0, irq});
    ck("ack after reset", 32'h0, {31'h0, ack_drive});
    rc("flags after reset", 4'h0, 8'h00);
    rc("mask after reset", 4'h8, 8'h00);
    rc("status after reset", 4'h4, 8'h00);
    wrap_up();
  end
endmodule : i2c_status_flag_logic_tb_top
